// *** rtl/irq_routing.sv ***
// Interrupt request routing, shared status byte and output inhibit.
// Assumes APB from the controller, backplane pins from outside pclk.
`default_nettype none

module irq_routing
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_WIDTH-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Function side
    input  wire logic                    irq_event,
    input  wire logic [DOUT_COUNT-1:0]   func_out,
    output logic      [DOUT_COUNT-1:0]   digital_out,
    // Backplane request lines, open drain, low when driven
    output logic      [LINE_COUNT-1:0]   request_line_out,
    output logic      [LINE_COUNT-1:0]   request_line_oe,
    // Backplane shared status byte
    input  wire logic                    status_read_n,
    output logic      [STATUS_WIDTH-1:0] status_byte_out,
    output logic      [STATUS_WIDTH-1:0] status_byte_oe,
    // Backplane output inhibit
    input  wire logic                    output_inhibit_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Keeps only the lowest set bit of a byte.
    function automatic logic [7:0] lowest_one(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 8'h00;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : lowest_one

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [14:0]             config_reg;
    logic                    pending_reg;
    logic                    pending_next;
    logic [LINE_COUNT-1:0]   line_oe_reg;
    logic [STATUS_WIDTH-1:0] sb_out_reg;
    logic [STATUS_WIDTH-1:0] sb_oe_reg;
    logic [DOUT_COUNT-1:0]   dout_reg;
    logic [1:0]              rd_sync_reg;
    logic [1:0]              inh_sync_reg;
    logic [31:0]             prdata_reg;
    logic                    slverr_reg;

    logic [STATUS_WIDTH-1:0] bit_select;
    logic [LINE_COUNT-1:0]   line_select;
    logic [LINE_COUNT-1:0]   line_onehot;
    logic                    role_slave;
    logic                    sb_enable;
    logic                    inh_response;
    logic                    status_read;
    logic                    inhibit;
    logic                    inhibit_active;
    logic [STATUS_WIDTH-1:0] sb_mask;
    logic [STATUS_WIDTH-1:0] sb_data;
    logic                    apb_access;
    logic                    apb_write;
    logic                    apb_read;
    logic                    addr_ok;
    logic                    ack_read;
    logic [7:0]              line_pick;

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    assign bit_select   = config_reg[CFG_BITSEL_LSB +: STATUS_WIDTH];
    assign line_select  = config_reg[CFG_LINE_LSB +: LINE_COUNT];
    assign role_slave   = config_reg[CFG_ROLE_BIT];
    assign sb_enable    = config_reg[CFG_SBEN_BIT];
    assign inh_response = config_reg[CFG_INHR_BIT];

    // Two closed line switches would short two lines; lowest one wins
    assign line_pick   = lowest_one({4'h0, line_select});
    assign line_onehot = line_pick[LINE_COUNT-1:0];

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    assign apb_access = psel & penable;
    assign apb_write  = apb_access & pwrite;
    assign apb_read   = apb_access & ~pwrite;
    assign addr_ok    = (paddr == OFF_CONFIG) || (paddr == OFF_STATUS) ||
                        (paddr == OFF_ACK);
    assign ack_read   = apb_read & (paddr == OFF_ACK);
    assign pready     = 1'b1;
    assign prdata     = prdata_reg;
    assign pslverr    = slverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= CFG_RESET;
        end else if (apb_write && paddr == OFF_CONFIG) begin
            config_reg <= pwdata[14:0];
        end
    end

    // Read data is registered, so it is valid in the access cycle only
    // when taken from the setup cycle's address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= ~addr_ok;
            case (paddr)
                OFF_CONFIG: prdata_reg[14:0] <= config_reg;
                OFF_STATUS: begin
                    prdata_reg[ST_PEND_BIT] <= pending_reg;
                    prdata_reg[ST_INH_BIT]  <= inhibit_active;
                    prdata_reg[ST_LINE_LSB +: LINE_COUNT] <= line_oe_reg;
                    prdata_reg[ST_DOUT_LSB +: DOUT_COUNT] <= dout_reg;
                end
                OFF_ACK:    prdata_reg[ST_PEND_BIT] <= pending_reg;
                default:    prdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            slverr_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_sync_reg  <= 2'h0;
            inh_sync_reg <= 2'h0;
        end else begin
            rd_sync_reg  <= {rd_sync_reg[0], ~status_read_n};
            inh_sync_reg <= {inh_sync_reg[0], ~output_inhibit_n};
        end
    end

    assign status_read = rd_sync_reg[1];
    assign inhibit     = inh_sync_reg[1];

    // ------------------------------------------------------------
    // Pending request
    // ------------------------------------------------------------
    // A new event in the acknowledge cycle wins, so it is never lost.
    always_comb begin
        pending_next = pending_reg;
        if (ack_read) begin
            pending_next = 1'b0;
        end
        if (irq_event) begin
            pending_next = 1'b1;
        end
    end

    // No CPU run or stop input: the CPU state cannot stall this logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= 1'b0;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // ------------------------------------------------------------
    // Request lines
    // ------------------------------------------------------------
    // Independent of the status byte, so lines can be shared.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_oe_reg <= 4'h0;
        end else begin
            line_oe_reg <= pending_reg ? line_onehot : 4'h0;
        end
    end

    assign request_line_oe  = line_oe_reg;
    assign request_line_out = 4'h0;

    // ------------------------------------------------------------
    // Shared status byte
    // ------------------------------------------------------------
    // Master drives every switched bit; only its own bit carries the
    // request, the rest read back as a masked zero.
    always_comb begin
        if (role_slave) begin
            sb_mask = lowest_one(bit_select);
            sb_data = pending_reg ? sb_mask : 8'h00;
        end else begin
            sb_mask = bit_select | 8'h01;
            sb_data = {7'h00, pending_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sb_out_reg <= 8'h00;
            sb_oe_reg  <= 8'h00;
        end else if (status_read && sb_enable) begin
            sb_out_reg <= sb_data;
            sb_oe_reg  <= sb_mask;
        end else begin
            sb_out_reg <= 8'h00;
            sb_oe_reg  <= 8'h00;
        end
    end

    assign status_byte_out = sb_out_reg;
    assign status_byte_oe  = sb_oe_reg;

    // ------------------------------------------------------------
    // Digital outputs with inhibit
    // ------------------------------------------------------------
    assign inhibit_active = inhibit & inh_response;

    // Registered each cycle, so release shows the demand one edge later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_reg <= 2'h0;
        end else if (inhibit_active) begin
            dout_reg <= 2'h0;
        end else begin
            dout_reg <= func_out;
        end
    end

    assign digital_out = dout_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_one_line;
        $onehot0(request_line_oe);
    endproperty
    a_one_line: assert property (p_one_line)
        else $error("more than one request line driven");
    property p_line_follow;
        pending_reg |=> request_line_oe == $past(line_onehot);
    endproperty
    a_line_follow: assert property (p_line_follow)
        else $error("request line does not follow selection");
    property p_event_sets;
        irq_event |=> pending_reg ##1 (request_line_oe == $past(line_onehot));
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("event did not raise request");
    property p_hold;
        pending_reg && !ack_read |=> pending_reg;
    endproperty
    a_hold: assert property (p_hold)
        else $error("pending request dropped without acknowledge");
    property p_ack_clears;
        ack_read && !irq_event |=> !pending_reg ##1 request_line_oe == 4'h0;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("acknowledge did not clear request");
    property p_inhibit;
        inhibit && inh_response |=> digital_out == 2'h0;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibit did not force outputs off");
    property p_no_inhibit;
        !inh_response |=> digital_out == $past(func_out);
    endproperty
    a_no_inhibit: assert property (p_no_inhibit)
        else $error("outputs changed by inhibit while ignored");
    property p_release;
        $fell(inhibit_active) |=> digital_out == $past(func_out);
    endproperty
    a_release: assert property (p_release)
        else $error("outputs did not return after inhibit");
    property p_slave_one_bit;
        role_slave |=> $onehot0(status_byte_oe);
    endproperty
    a_slave_one_bit: assert property (p_slave_one_bit)
        else $error("slave drives more than one status bit");
    property p_sb_disabled;
        !sb_enable |=> status_byte_oe == 8'h00;
    endproperty
    a_sb_disabled: assert property (p_sb_disabled)
        else $error("status byte driven while disabled");

    property p_master_bit0;
        !role_slave && sb_enable && status_read |=>
            status_byte_oe[0] && status_byte_out[0] == $past(pending_reg);
    endproperty
    a_master_bit0: assert property (p_master_bit0)
        else $error("master bit zero wrong");

    c_event:   cover property (irq_event ##1 pending_reg);
    c_ack:     cover property (pending_reg ##1 ack_read ##1 !pending_reg);
    c_inhibit: cover property (inhibit_active ##1 !inhibit_active);
    c_sb_read: cover property (status_read && sb_enable && pending_reg);

endmodule : irq_routing

`default_nettype wire

// *** rtl/irq_pkg.sv ***
// Constants for the interrupt routing and output inhibit block.
// Assumes a 32-bit APB master on pclk (10 MHz) and a byte-wide backplane.
`default_nettype none

package irq_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned LINE_COUNT   = 4;
    localparam int unsigned STATUS_WIDTH = 8;
    localparam int unsigned DOUT_COUNT   = 2;
    localparam int unsigned ADDR_WIDTH   = 8;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ACK    = 8'h08;

    // ------------------------------------------------------------
    // Configuration register fields
    // ------------------------------------------------------------
    localparam int unsigned CFG_BITSEL_LSB = 0;
    localparam int unsigned CFG_LINE_LSB   = 8;
    localparam int unsigned CFG_ROLE_BIT   = 12;
    localparam int unsigned CFG_SBEN_BIT   = 13;
    localparam int unsigned CFG_INHR_BIT   = 14;
    localparam logic [14:0] CFG_RESET      = 15'h0000;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int unsigned ST_PEND_BIT  = 0;
    localparam int unsigned ST_INH_BIT   = 1;
    localparam int unsigned ST_LINE_LSB  = 2;
    localparam int unsigned ST_DOUT_LSB  = 6;

endpackage : irq_pkg

`default_nettype wire

// *** tb/irq_cpu_model.sv ***
// Behavioural controller CPU on the backplane for the routing block.
// Assumes pull-ups on the request lines and the shared status byte.
`default_nettype none

module irq_cpu_model (
    // Clock
    input  wire logic       pclk,
    // Request lines
    input  wire logic [3:0] request_line_out,
    input  wire logic [3:0] request_line_oe,
    output logic      [3:0] request_lines,
    // Shared status byte
    input  wire logic [7:0] status_byte_out,
    input  wire logic [7:0] status_byte_oe,
    output logic            status_read_n,
    // Output inhibit
    output logic            output_inhibit_n
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        status_read_n = 1'b1;
        output_inhibit_n = 1'b1;
    end

    // -----------------------------------------------------------
    // Wire resolution
    // -----------------------------------------------------------
    // Released open-drain lines float high through the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            request_lines[i] = request_line_oe[i] ? request_line_out[i] : 1'b1;
        end
    end

    // -----------------------------------------------------------
    // Bus actions
    // -----------------------------------------------------------
    // No input module answers at byte zero while it is read
    task read_byte(output logic [7:0] oe_s, output logic [7:0] out_s,
                   output logic [7:0] bus_s);
        @(posedge pclk);
        status_read_n <= 1'b0;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        oe_s = status_byte_oe;
        out_s = status_byte_out;
        // Undriven bits read high, so unmasked bits look pending
        for (int i = 0; i < 8; i++) begin
            bus_s[i] = oe_s[i] ? out_s[i] : 1'b1;
        end
        @(posedge pclk);
        status_read_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : read_byte

    // Bit zero first bits not reserved are ignored
    function automatic int first_pending(input logic [7:0] bus,
                                         input logic [7:0] reserved);
        for (int i = 0; i < 8; i++) begin
            if ((bus[i] & reserved[i]) === 1'b1) begin
                return i;
            end
        end
        return 8;
    endfunction : first_pending

    // Whether a change of the byte starts the service routine:
    // any change with a nonzero selector, otherwise rises only
    function automatic logic service_due(
        input logic [7:0]  prev_b,
        input logic [7:0]  cur_b,
        input int unsigned trigger_edge_selector,
        input logic [2:0]  bit_idx
    );
        if (trigger_edge_selector > 0) begin
            return prev_b[bit_idx] != cur_b[bit_idx];
        end
        return !prev_b[bit_idx] && cur_b[bit_idx];
    endfunction : service_due

    task set_inhibit(input logic on);
        @(posedge pclk);
        output_inhibit_n <= !on;
    endtask : set_inhibit

endmodule : irq_cpu_model

`default_nettype wire

// *** tb/irq_routing_test.sv ***
// Self-checking bench for the interrupt routing block.
// Assumes an APB slave on pclk and the CPU model alongside.
`default_nettype none

module irq_routing_test;
    import irq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, so_oe, so_out, so_bus, st_oe, st_out;
    logic [31:0] pwdata, prdata, rd;
    logic        irq_event, er, status_read_n, output_inhibit_n;
    logic [7:0]  prev_bus;
    logic        due;
    logic [1:0]  func_out, digital_out;
    logic [3:0]  rl_out, rl_oe, rl_wire;
    int          fails, n_checks;

    irq_routing irq_routing_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_event(irq_event),
        .func_out(func_out), .digital_out(digital_out),
        .request_line_out(rl_out), .request_line_oe(rl_oe),
        .status_read_n(status_read_n), .status_byte_out(st_out),
        .status_byte_oe(st_oe), .output_inhibit_n(output_inhibit_n)
    );

    irq_cpu_model irq_cpu_model_inst (
        .pclk(pclk), .request_line_out(rl_out), .request_line_oe(rl_oe),
        .request_lines(rl_wire), .status_byte_out(st_out),
        .status_byte_oe(st_oe), .status_read_n(status_read_n),
        .output_inhibit_n(output_inhibit_n)
    );

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task conclude;
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    // Event sampled at edge N, line driven at N+1
    task fire;
        @(posedge pclk);
        irq_event <= 1'b1;
        @(posedge pclk);
        irq_event <= 1'b0;
        settle(2);
    endtask : fire

    task ack;
        apb(1'b0, OFF_ACK, 32'h0);
        chk(rd, 32'h1);
        settle(2);
        chk({28'h0, rl_oe}, 32'h0);
    endtask : ack

    // -----------------------------------------------------------
    // Clock, watchdog, tests
    // -----------------------------------------------------------
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    initial begin
        #(100 * 5000);
        fails++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, irq_event} = 5'h00;
        {paddr, pwdata, func_out} = '0;
        fails = 0;
        n_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFF_STATUS, 32'hFF);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h0C, 32'h7FFF);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, OFF_CONFIG, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CONFIG, 32'h100 << i);
            fire();
            chk({28'h0, rl_oe}, 32'h1 << i);
            chk({28'h0, rl_wire}, {28'h0, ~(4'h1 << i)});
            apb(1'b0, OFF_STATUS, 32'h0);
            chk(rd, (32'h4 << i) | 32'h1);
            ack();
        end
        // Two line bits set: only the lowest may drive
        apb(1'b1, OFF_CONFIG, 32'h600);
        fire();
        chk({28'h0, rl_oe}, 32'h2);
        ack();
        // Slave sharing line a, bit 2
        apb(1'b1, OFF_CONFIG, 32'h3104);
        irq_cpu_model_inst.read_byte(so_oe, so_out, prev_bus);
        fire();
        irq_cpu_model_inst.read_byte(so_oe, so_out, so_bus);
        chk({24'h0, so_oe}, 32'h04);
        chk({24'h0, so_out}, 32'h04);
        chk({28'h0, rl_oe}, 32'h1);
        // Undriven bits float high; only the reserved bit counts
        chk(irq_cpu_model_inst.first_pending(so_bus, 8'h04), 2);
        due = irq_cpu_model_inst.service_due(prev_bus, so_bus, 0, 3'd2);
        chk({31'h0, due}, 32'h1);
        ack();
        prev_bus = so_bus;
        // Handler rereads the byte before it returns
        irq_cpu_model_inst.read_byte(so_oe, so_out, so_bus);
        chk({24'h0, so_out}, 32'h00);
        due = irq_cpu_model_inst.service_due(prev_bus, so_bus, 0, 3'd2);
        chk({31'h0, due}, 32'h0);
        due = irq_cpu_model_inst.service_due(prev_bus, so_bus, 1, 3'd2);
        chk({31'h0, due}, 32'h1);
        // Master masking bit 7
        apb(1'b1, OFF_CONFIG, 32'h2081);
        fire();
        irq_cpu_model_inst.read_byte(so_oe, so_out, so_bus);
        chk({24'h0, so_oe}, 32'h81);
        chk({24'h0, so_out}, 32'h01);
        ack();
        // Status byte disabled: nothing driven
        apb(1'b1, OFF_CONFIG, 32'h0081);
        fire();
        irq_cpu_model_inst.read_byte(so_oe, so_out, so_bus);
        chk({24'h0, so_oe}, 32'h00);
        ack();
        // Output inhibit with and without response
        @(posedge pclk);
        func_out <= 2'b10;
        apb(1'b1, OFF_CONFIG, 32'h4000);
        settle(2);
        chk({30'h0, digital_out}, 32'h2);
        irq_cpu_model_inst.set_inhibit(1'b1);
        settle(4);
        chk({30'h0, digital_out}, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h2);
        irq_cpu_model_inst.set_inhibit(1'b0);
        settle(4);
        chk({30'h0, digital_out}, 32'h2);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, 32'h80);
        apb(1'b1, OFF_CONFIG, 32'h0);
        irq_cpu_model_inst.set_inhibit(1'b1);
        settle(4);
        chk({30'h0, digital_out}, 32'h2);
        conclude();
    end

endmodule : irq_routing_test

`default_nettype wire
